// File: delay_timer.sv
// Restartable down-counter flagging that a fixed delay has elapsed.
// Assumes run is a level from logic on clk; done is held while run stays high.
`timescale 1ns/1ps
module delay_timer #(
  parameter int unsigned CYCLES = 16
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic run,
  output logic      done
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_r;   // Cycles left

  // ********************************************************************
  // Counter: reloads while run is low, counts to zero while high
  // ********************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= CW'(CYCLES);
      done  <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt_r <= CW'(CYCLES);
        done  <= 1'b0;
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1;
        done  <= (cnt_r == CW'(1));
      end
    end
  end

endmodule

// File: drive_checker.sv
// Checker for the drive power state machine, bound to its ports.
// Assumes ce is held high and a single clock domain.
`timescale 1ns/1ps
module drive_checker
  import drive_pkg::*;
#(
  parameter int unsigned READY_CYCLES = 20,
  parameter int unsigned INIT_CYCLES  = 16
) (
  input wire logic         clk,
  input wire logic         rst_n,
  input wire logic         param_wr,
  input wire logic         param_refused,
  input wire logic  [15:0] status_word,
  input wire logic  [15:0] command_word,
  input wire logic         motor_excite,
  input wire logic         motion_ready_output,
  input wire logic         motion_cmd_gate,
  input wire logic  [7:0]  alarm_code,
  input wire drive_state_e drive_state
);
  // Status code per state; bit 4 is power, masked
  localparam logic [6:0] CODE [8] = '{STS_NOT_READY, STS_SW_DISABLED, STS_SWITCHED_ON,
    STS_READY, STS_FAULT, STS_FAULT_REACT, STS_OP_ENABLED, STS_QSTOP};
  logic [31:0] open_cnt_r;  // Cycles in operation-enabled, restarts on each entry
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Residence counter, too long for a repetition
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) open_cnt_r <= '0;
    else open_cnt_r <= (drive_state == ST_OP_ENABLED) ? open_cnt_r + 32'h1 : '0;
  end
  sequence s_leave_fault;
    $past(drive_state) == ST_FAULT ##0 drive_state != ST_FAULT;
  endsequence
  sequence s_alarm_set;
    $past(alarm_code) == ALM_NONE ##0 alarm_code != ALM_NONE;
  endsequence
  a_excite_by_state: assert property (
    motor_excite == ($past(drive_state) inside {ST_OP_ENABLED, ST_QSTOP, ST_FAULT_REACT}))
    else $error("excitation does not match state");
  a_status_state_code: assert property (
    (status_word[6:0] & 7'h6F) == CODE[$past(drive_state)] && status_word[15:7] == 9'h000)
    else $error("status word does not match state");
  a_ready_not_early: assert property (
    motion_ready_output |-> $past(open_cnt_r) >= READY_CYCLES)
    else $error("motion ready too early");
  a_ready_on_time: assert property (
    open_cnt_r == READY_CYCLES + 1 |-> motion_ready_output) else $error("motion ready late");
  a_gate_halt_bit: assert property (
    motion_cmd_gate == (motion_ready_output && !command_word[8])) else $error("gate wrong");
  a_refuse_not_ready: assert property (
    param_wr && drive_state == ST_NOT_READY && $past(rst_n, 3) |=> param_refused)
    else $error("write in not-ready not refused");
  a_init_then_disabled: assert property (
    $fell(drive_state == ST_NOT_READY) |->
      drive_state == ST_SW_DISABLED && $past(drive_state == ST_NOT_READY, 8))
    else $error("initialization exit wrong");
  a_fault_exit_edge: assert property (
    s_leave_fault |-> drive_state == ST_SW_DISABLED && $past(command_word[7])
      && !$past(command_word[7], 2)) else $error("fault left without reset edge");
  a_alarm_to_fault: assert property (
    s_alarm_set |-> ##[0:2] drive_state inside {ST_FAULT_REACT, ST_FAULT})
    else $error("alarm without fault reaction");
endmodule
bind drive_power_state_machine drive_checker #(
  .READY_CYCLES(READY_CYCLES), .INIT_CYCLES(INIT_CYCLES)) i_drive_checker (.clk, .rst_n,
  .param_wr, .param_refused, .status_word, .command_word, .motor_excite,
  .motion_ready_output, .motion_cmd_gate, .alarm_code, .drive_state);

// File: drive_master_model.sv
// Fieldbus master model: writes command words into the parameter port.
// Assumes one clock and one write in flight at a time.
`timescale 1ns/1ps
module drive_master_model
  import drive_pkg::*;
(
  input  wire logic        clk,
  output logic             param_wr,
  output logic      [15:0] param_addr,
  output logic      [15:0] param_wdata
);
  initial begin
    param_wr    = 1'b0;
    param_addr  = CMD_WORD_OFFSET;
    param_wdata = 16'hFFFF;
  end
  // One-cycle strobe; data inverted after it so stale words never pass
  task automatic put(input logic [15:0] word);
    @(posedge clk);
    #1;
    param_wr    = 1'b1;
    param_wdata = word;
    @(posedge clk);
    #1;
    param_wr    = 1'b0;
    param_wdata = ~word;
  endtask
endmodule

// File: drive_pkg.sv
// Package for the drive power state machine: command bits, states, status codes, timing.
// Assumes a 10 MHz system clock; all files compile after this one.
package drive_pkg;

  // ********************************************************************
  // Clock and timing
  // ********************************************************************
  localparam int unsigned CLK_HZ          = 10_000_000;  // System clock rate
  localparam int unsigned READY_DELAY_MS  = 250;         // Excitation preparation time
  localparam int unsigned READY_DELAY_CYC = READY_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned INIT_CYC        = 16;          // Initialization length after power-up

  // ********************************************************************
  // Register offsets and reset values
  // ********************************************************************
  localparam logic [15:0] CMD_WORD_OFFSET = 16'h6040;    // Command word object
  localparam logic [15:0] STS_WORD_OFFSET = 16'h6041;    // Status word object
  localparam logic [15:0] CMD_WORD_RESET  = 16'h0000;    // Command word after reset

  // ********************************************************************
  // Command word field positions
  // ********************************************************************
  localparam int unsigned CMD_SWITCH_ON   = 0;
  localparam int unsigned CMD_EN_VOLTAGE  = 1;
  localparam int unsigned CMD_QSTOP_N     = 2;   // Quick stop, active low
  localparam int unsigned CMD_EN_OP       = 3;
  localparam int unsigned CMD_FAULT_RESET = 7;
  localparam int unsigned CMD_HALT        = 8;

  // ********************************************************************
  // Status word field positions and state codes (bits 6..0)
  // ********************************************************************
  localparam int unsigned STS_VOLTAGE_EN  = 4;
  localparam logic [6:0] STS_NOT_READY   = 7'h00;
  localparam logic [6:0] STS_SW_DISABLED = 7'h40;
  localparam logic [6:0] STS_READY       = 7'h21;
  localparam logic [6:0] STS_SWITCHED_ON = 7'h23;
  localparam logic [6:0] STS_OP_ENABLED  = 7'h27;
  localparam logic [6:0] STS_QSTOP       = 7'h07;
  localparam logic [6:0] STS_FAULT_REACT = 7'h2F;
  localparam logic [6:0] STS_FAULT       = 7'h28;

  // ********************************************************************
  // Alarm codes
  // ********************************************************************
  localparam logic [7:0] ALM_NONE       = 8'h00;
  localparam logic [7:0] ALM_NETWORK    = 8'h81;
  localparam logic [7:0] ALM_MAIN_POWER = 8'h23;

  // ********************************************************************
  // Types
  // ********************************************************************
  // Gray codes along the usual power-up path
  typedef enum logic [2:0] {
    ST_NOT_READY   = 3'h0,
    ST_SW_DISABLED = 3'h1,
    ST_READY       = 3'h3,
    ST_SWITCHED_ON = 3'h2,
    ST_OP_ENABLED  = 3'h6,
    ST_QSTOP       = 3'h7,
    ST_FAULT_REACT = 3'h5,
    ST_FAULT       = 3'h4
  } drive_state_e;

  // Plant conditions seen by the state machine
  typedef struct packed {
    logic net_operational;  // Network state is Operational
    logic main_power;       // Main power present
    logic deexcite;         // De-excitation input on
    logic tool_test;        // Tool-driven test operation running
    logic motor_running;    // Motor in motion
  } plant_s;

endpackage

// File: drive_power_state_machine.sv
// Drive power state machine: command word in, status word out, excitation gating.
// Assumes the master writes the command word through the parameter port and that
// plant inputs arrive asynchronously from pins; alarm sources beyond two are external.
//
// What this block does
// - Hold not-ready during init; refuse writes then
// - Excite only in enabled, quick-stop, fault-reaction
// - 250 ms preparation; ignore early motion commands
// - Command bit layout: 0,1,2n,3,7,8
// - Decode shutdown, switch-on, switch-on plus enable
// - Disable voltage and quick-stop transitions
// - Disable and enable operation transitions
// - Fault cleared only on reset rising edge
// - Ready to switched-on needs four conditions
// - Auto not-ready at power-up, then disabled
// - Quick-stop option 1..3: halt then disabled
// - Alarm: excited fault reaction, then fault
// - Stopped events drop back to ready
// - Network loss while running raises 81h
// - Main power loss while running raises 23h
// - De-excite while running returns to ready
// - Quick-stop events lead to switch-on disabled
// - State readable in status word anytime
// - Status bits 6..0 state, bit 4 power
`timescale 1ns/1ps
module drive_power_state_machine
  import drive_pkg::*;
#(
  parameter int unsigned READY_CYCLES = READY_DELAY_CYC,  // Excitation preparation time
  parameter int unsigned INIT_CYCLES  = INIT_CYC,         // Initialization time
  parameter int unsigned QS_OPT_W     = 16                // Quick-stop option width
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                ce,
  // Parameter port
  input  wire logic                param_wr,         // Write strobe
  input  wire logic [15:0]         param_addr,       // Object index
  input  wire logic [15:0]         param_wdata,      // Write data
  output logic                     param_refused,    // Write refused in not-ready
  output logic      [15:0]         status_word,      // State report
  output logic      [15:0]         command_word,     // Current command word
  // Quick-stop option setting and alarms
  input  wire logic [QS_OPT_W-1:0] quick_stop_option,
  input  wire logic                ext_alarm,        // Other alarm sources
  // Plant pins (asynchronous)
  input  wire logic                net_operational,
  input  wire logic                main_power,
  input  wire logic                deexcite_in,
  input  wire logic                tool_test,
  input  wire logic                motor_running,
  input  wire logic                fault_stop_done,  // Fault reaction stop finished
  // Outputs
  output logic                     motor_excite,
  output logic                     motion_ready_output,
  output logic                     motion_cmd_gate,  // Motion commands accepted
  output logic      [7:0]          alarm_code,
  output drive_state_e             drive_state
);

  // ********************************************************************
  // Reset release and input synchronisation
  // ********************************************************************
  logic [1:0]   rst_sync_r;   // Reset release chain
  logic         rst_int_n;    // Internal reset copy
  plant_s       plant_raw;    // Raw pin group
  plant_s       plant;        // Filtered pin group
  logic         stop_done;    // Filtered fault-stop-done

  // Release reset through two flops so every flop leaves reset together
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_r[1];

  assign plant_raw = '{net_operational: net_operational, main_power: main_power,
                       deexcite: deexcite_in, tool_test: tool_test,
                       motor_running: motor_running};

  pin_sync #(.WIDTH(6)) u_pins (
    .clk   (clk),
    .rst_n (rst_int_n),
    .ce    (ce),
    .din   ({plant_raw, fault_stop_done}),
    .dout  ({plant, stop_done})
  );

  // ********************************************************************
  // Command word register and update detection
  // ********************************************************************
  logic         cmd_new_r;    // A new command word waits to be evaluated
  logic         fr_prev_r;    // Fault-reset bit at previous evaluation
  logic         refuse_r;     // Refused-write flag
  drive_state_e state_r;      // Current state
  drive_state_e state_nxt;    // Next state

  // Store writes except in not-ready, which locks out parameters
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      command_word <= CMD_WORD_RESET;
      cmd_new_r    <= 1'b0;
      refuse_r     <= 1'b0;
    end else if (ce) begin
      refuse_r <= 1'b0;
      if (param_wr && (param_addr == CMD_WORD_OFFSET)) begin
        if (state_r == ST_NOT_READY) begin
          refuse_r <= 1'b1;
        end else begin
          command_word <= param_wdata;
          cmd_new_r    <= 1'b1;
        end
      end else if (param_wr) begin
        // Other parameters are stored elsewhere; still locked in not-ready
        refuse_r  <= (state_r == ST_NOT_READY);
        cmd_new_r <= 1'b0;
      end else begin
        cmd_new_r <= 1'b0;                  // Each word evaluated once
      end
    end
  end
  assign param_refused = refuse_r;

  // Fault reset edge history, sampled on each evaluated word
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      fr_prev_r <= 1'b0;
    end else if (ce && cmd_new_r) begin
      fr_prev_r <= command_word[CMD_FAULT_RESET];
    end
  end

  // ********************************************************************
  // Command decode
  // ********************************************************************
  logic c_so;        // Switch on
  logic c_ev;        // Enable voltage
  logic c_qs_n;      // Quick stop, active low
  logic c_eo;        // Enable operation
  logic fr_rise;     // Fault reset 0 to 1
  logic cmd_shutdown;
  logic cmd_switch_on;
  logic cmd_enable;
  logic cmd_disable_v;
  logic cmd_qstop;
  logic sw_on_ok;    // Switch-on permitted by plant
  logic any_event;   // Any of the three plant events
  logic alarm_any;   // Alarm present
  logic qs_opt_halt; // Option 1..3
  logic init_done;   // Initialization finished
  logic prep_done;   // Excitation preparation finished

  assign c_so   = command_word[CMD_SWITCH_ON];
  assign c_ev   = command_word[CMD_EN_VOLTAGE];
  assign c_qs_n = command_word[CMD_QSTOP_N];
  assign c_eo   = command_word[CMD_EN_OP];

  assign cmd_shutdown  = c_qs_n & c_ev & ~c_so;
  assign cmd_switch_on = c_qs_n & c_ev & c_so & ~c_eo;
  assign cmd_enable    = c_qs_n & c_ev & c_so & c_eo;
  assign cmd_disable_v = ~c_ev;
  assign cmd_qstop     = ~c_qs_n & c_ev;
  assign fr_rise       = command_word[CMD_FAULT_RESET] & ~fr_prev_r;

  // Four permissions for the ready to switched-on step
  assign sw_on_ok  = plant.net_operational & plant.main_power &
                     ~plant.deexcite & ~plant.tool_test;
  assign any_event = ~plant.net_operational | ~plant.main_power | plant.deexcite;
  assign alarm_any = ext_alarm;
  assign qs_opt_halt = (quick_stop_option >= QS_OPT_W'(1)) &&
                       (quick_stop_option <= QS_OPT_W'(3));

  // ********************************************************************
  // Timers
  // ********************************************************************
  delay_timer #(.CYCLES(INIT_CYCLES)) u_init (
    .clk   (clk),
    .rst_n (rst_int_n),
    .ce    (ce),
    .run   (state_r == ST_NOT_READY),
    .done  (init_done)
  );

  // Restarts on every entry to operation-enabled
  delay_timer #(.CYCLES(READY_CYCLES)) u_prep (
    .clk   (clk),
    .rst_n (rst_int_n),
    .ce    (ce),
    .run   (state_r == ST_OP_ENABLED),
    .done  (prep_done)
  );

  // ********************************************************************
  // State transitions
  // ********************************************************************
  logic [7:0] alarm_nxt;

  // Plant events act every cycle; commands act only on a fresh word
  always_comb begin
    state_nxt = state_r;
    alarm_nxt = alarm_code;
    case (state_r)
      ST_NOT_READY: begin
        if (init_done) begin
          state_nxt = ST_SW_DISABLED;
        end
      end
      ST_SW_DISABLED: begin
        if (alarm_any) begin
          state_nxt = ST_FAULT_REACT;
        end else if (cmd_new_r && cmd_shutdown) begin
          state_nxt = ST_READY;
        end
      end
      ST_READY: begin
        if (alarm_any) begin
          state_nxt = ST_FAULT_REACT;
        end else if (cmd_new_r) begin
          if (cmd_disable_v || cmd_qstop) begin
            state_nxt = ST_SW_DISABLED;
          end else if ((cmd_switch_on || cmd_enable) && sw_on_ok) begin
            // Switch on plus enable passes straight through
            state_nxt = cmd_enable ? ST_OP_ENABLED : ST_SWITCHED_ON;
          end
        end
      end
      ST_SWITCHED_ON: begin
        if (alarm_any) begin
          state_nxt = ST_FAULT_REACT;
        end else if (any_event && !plant.motor_running) begin
          state_nxt = ST_READY;
        end else if (cmd_new_r) begin
          if (cmd_disable_v || cmd_qstop) begin
            state_nxt = ST_SW_DISABLED;
          end else if (cmd_shutdown) begin
            state_nxt = ST_READY;
          end else if (cmd_enable) begin
            state_nxt = ST_OP_ENABLED;
          end
        end
      end
      ST_OP_ENABLED: begin
        if (alarm_any) begin
          state_nxt = ST_FAULT_REACT;
        end else if (plant.motor_running && !plant.net_operational) begin
          state_nxt = ST_FAULT_REACT;
          alarm_nxt = ALM_NETWORK;
        end else if (plant.motor_running && !plant.main_power) begin
          state_nxt = ST_FAULT_REACT;
          alarm_nxt = ALM_MAIN_POWER;
        end else if (any_event) begin
          state_nxt = ST_READY;
        end else if (cmd_new_r) begin
          if (cmd_disable_v) begin
            state_nxt = ST_SW_DISABLED;
          end else if (cmd_qstop) begin
            state_nxt = ST_QSTOP;
          end else if (cmd_shutdown) begin
            state_nxt = ST_READY;
          end else if (cmd_switch_on) begin
            state_nxt = ST_SWITCHED_ON;
          end
        end
      end
      ST_QSTOP: begin
        if (alarm_any) begin
          state_nxt = ST_FAULT_REACT;
        end else if (plant.motor_running && !plant.net_operational) begin
          state_nxt = ST_FAULT_REACT;
          alarm_nxt = ALM_NETWORK;
        end else if (plant.motor_running && !plant.main_power) begin
          state_nxt = ST_FAULT_REACT;
          alarm_nxt = ALM_MAIN_POWER;
        end else if (any_event) begin
          state_nxt = ST_SW_DISABLED;
        end else if (qs_opt_halt && !plant.motor_running) begin
          state_nxt = ST_SW_DISABLED;
        end else if (cmd_new_r) begin
          if (cmd_disable_v) begin
            state_nxt = ST_SW_DISABLED;
          end else if (cmd_enable) begin
            state_nxt = ST_OP_ENABLED;
          end
        end
      end
      ST_FAULT_REACT: begin
        // Motor stays excited until the stop completes
        if (stop_done || !plant.motor_running) begin
          state_nxt = ST_FAULT;
        end
      end
      ST_FAULT: begin
        // Only a rising fault-reset bit clears; alarm must have gone
        if (cmd_new_r && fr_rise && !alarm_any) begin
          state_nxt = ST_SW_DISABLED;
          alarm_nxt = ALM_NONE;
        end
      end
      default: begin
        state_nxt = ST_NOT_READY;
      end
    endcase
  end

  // State register: not-ready from power-up
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      state_r <= ST_NOT_READY;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // Alarm code register
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      alarm_code <= ALM_NONE;
    end else if (ce) begin
      alarm_code <= alarm_nxt;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  logic [6:0] sts_code;   // State code for bits 6..0

  // Status codes per state
  always_comb begin
    case (state_r)
      ST_SW_DISABLED: sts_code = STS_SW_DISABLED;
      ST_READY:       sts_code = STS_READY;
      ST_SWITCHED_ON: sts_code = STS_SWITCHED_ON;
      ST_OP_ENABLED:  sts_code = STS_OP_ENABLED;
      ST_QSTOP:       sts_code = STS_QSTOP;
      ST_FAULT_REACT: sts_code = STS_FAULT_REACT;
      ST_FAULT:       sts_code = STS_FAULT;
      default:        sts_code = STS_NOT_READY;
    endcase
  end

  // Registered status word; bit 4 tracks main power outside not-ready
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      status_word <= 16'h0000;
    end else if (ce) begin
      status_word <= {9'h000, sts_code};
      if (state_r != ST_NOT_READY) begin
        status_word[STS_VOLTAGE_EN] <= plant.main_power;
      end
    end
  end

  // Excitation and readiness, registered
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      motor_excite        <= 1'b0;
      motion_ready_output <= 1'b0;
    end else if (ce) begin
      motor_excite <= (state_r == ST_OP_ENABLED) || (state_r == ST_QSTOP) ||
                      (state_r == ST_FAULT_REACT);
      motion_ready_output <= prep_done && (state_r == ST_OP_ENABLED);
    end
  end

  // Motion commands pass only once ready and not halted
  assign motion_cmd_gate = motion_ready_output & ~command_word[CMD_HALT];
  assign drive_state     = state_r;

endmodule

// File: pin_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to clk; output changes once stages two and three agree.
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1_r;   // First stage, read only by s2_r
  logic [WIDTH-1:0] s2_r;   // Second stage
  logic [WIDTH-1:0] s3_r;   // Third stage

  // ********************************************************************
  // Shift chain
  // ********************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else if (ce) begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accept a bit only when stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= '0;
    end else if (ce) begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          dout[i] <= s3_r[i];
        end
      end
    end
  end

endmodule

// File: testbench.sv
// Testbench: command sequences and plant events against expected states.
// Assumes a 10 MHz clock and a short preparation time.
`timescale 1ns/1ps
module testbench
  import drive_pkg::*;
;
  logic         clk, rst_n, net_operational, main_power, deexcite_in, motor_running;
  logic         ext_alarm = 1'b0, tool_test = 1'b0, fault_stop_done = 1'b0;
  logic         param_wr, param_refused, motor_excite, motion_ready_output, motion_cmd_gate;
  logic  [15:0] param_addr, param_wdata, status_word, command_word;
  logic  [7:0]  alarm_code;
  drive_state_e drive_state;
  int           err_total = 0;
  int           tests_run = 0;
  drive_power_state_machine #(.READY_CYCLES(20), .INIT_CYCLES(16)) i_drive_power_state_machine (
    .clk, .rst_n, .ce(1'b1), .param_wr, .param_addr, .param_wdata, .param_refused,
    .status_word, .command_word, .quick_stop_option(16'h0001), .ext_alarm,
    .net_operational, .main_power, .deexcite_in, .tool_test, .motor_running,
    .fault_stop_done, .motor_excite, .motion_ready_output, .motion_cmd_gate,
    .alarm_code, .drive_state);
  drive_master_model i_drive_master_model (.clk, .param_wr, .param_addr, .param_wdata);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      err_total++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait for a state, then compare
  task automatic settle(input drive_state_e st, input logic [15:0] sts);
    for (int n = 0; n < 80 && drive_state !== st; n++) @(posedge clk);
    cyc(3);
    check(16'(drive_state), 16'(st));
    check(status_word, sts);
  endtask
  task automatic go(input logic [15:0] w, input drive_state_e st, input logic [15:0] sts);
    i_drive_master_model.put(w);
    settle(st, sts);
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Tests take about 360 cycles
  initial begin
    #2_000_000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    rst_n = 1'b0;
    net_operational = 1'b1;
    main_power = 1'b1;
    deexcite_in = 1'b0;
    motor_running = 1'b0;
    cyc(4);
    rst_n = 1'b1;
    cyc(5);
    i_drive_master_model.put(16'h0006);
    check(16'(param_refused), 16'h0001);
    cyc(1);
    check(command_word, 16'h0000);
    settle(ST_SW_DISABLED, 16'h0050);
    go(16'h0007, ST_SW_DISABLED, 16'h0050);
    go(16'h0006, ST_READY, 16'h0031);
    main_power = 1'b0;
    cyc(8);
    go(16'h000F, ST_READY, 16'h0021);
    {main_power, tool_test} = 2'h3;
    cyc(8);
    go(16'h000F, ST_READY, 16'h0031);
    tool_test = 1'b0;
    cyc(8);
    go(16'h000F, ST_OP_ENABLED, 16'h0037);
    check(16'(motion_ready_output), 16'h0000);
    cyc(30); // Wait out the preparation time before checking the gate
    check(16'(motion_cmd_gate), 16'h0001);
    check(16'(motor_excite), 16'h0001);
    go(16'h010F, ST_OP_ENABLED, 16'h0037);
    check(16'(motion_cmd_gate), 16'h0000);
    go(16'h0007, ST_SWITCHED_ON, 16'h0033);
    check(16'(motor_excite), 16'h0000);
    go(16'h000F, ST_OP_ENABLED, 16'h0037);
    go(16'h000B, ST_SW_DISABLED, 16'h0050);
    go(16'h0006, ST_READY, 16'h0031);
    go(16'h0002, ST_SW_DISABLED, 16'h0050);
    // De-excitation, motor stopped then running
    for (int m = 0; m < 2; m++) begin
      go(16'h0006, ST_READY, 16'h0031);
      go(16'h000F, ST_OP_ENABLED, 16'h0037);
      motor_running = m[0];
      cyc(8);
      deexcite_in = 1'b1;
      settle(ST_READY, 16'h0031);
      check({8'h00, alarm_code}, 16'h0000);
      deexcite_in = 1'b0;
      motor_running = 1'b0;
      cyc(8);
    end
    // Network loss, then main power loss, running
    for (int k = 0; k < 2; k++) begin
      go(16'h0006, ST_READY, 16'h0031);
      go(k ? 16'h008F : 16'h000F, ST_OP_ENABLED, 16'h0037);
      motor_running = 1'b1;
      cyc(8);
      if (k == 0) net_operational = 1'b0;
      else main_power = 1'b0;
      settle(ST_FAULT_REACT, k ? 16'h002F : 16'h003F);
      check({8'h00, alarm_code}, k ? 16'h0023 : 16'h0081);
      check(16'(motor_excite), 16'h0001);
      motor_running = k[0];
      fault_stop_done = k[0];
      settle(ST_FAULT, k ? 16'h0028 : 16'h0038);
      check(16'(motor_excite), 16'h0000);
      net_operational = 1'b1;
      main_power = 1'b1;
      cyc(8);
      go(16'h0080, k ? ST_FAULT : ST_SW_DISABLED, k ? 16'h0038 : 16'h0050);
      go(16'h0000, k ? ST_FAULT : ST_SW_DISABLED, k ? 16'h0038 : 16'h0050);
      go(16'h0080, ST_SW_DISABLED, 16'h0050);
      check({8'h00, alarm_code}, 16'h0000);
    end
    ext_alarm = 1'b1;
    settle(ST_FAULT, 16'h0038);
    tally_and_finish();
  end
endmodule
